// file: irq_bank.v
// Purpose: one eight-level interrupt bank: sensing, mask, priority, ack
// Assumes: INTA1/INTA2 and commands are synchronous to CLK
// Notes:   request pins are asynchronous and are synchronised here
`timescale 1ns/100ps
`default_nettype none
`include "irq_bank_defines.vh"

module irq_bank (
  input  wire        CLK,            // 25 MHz system clock
  input  wire        RESET_N,        // async reset, active low
  input  wire [7:0]  IRQ_N,          // request pins, active low
  input  wire        LEVEL_MODE,     // 1 level sensing, 0 edge
  input  wire        MASK_WR,        // pulse: load mask
  input  wire [7:0]  MASK_DATA,      // new mask value
  input  wire        CMD_VALID,      // pulse: command present
  input  wire [3:0]  CMD_CODE,       // command code
  input  wire [2:0]  CMD_LEVEL,      // level for specific commands
  input  wire [7:0]  CASCADE_EN,     // level has a slave behind it
  input  wire [63:0] VECTOR_TABLE,   // eight vector bytes, level 0 low
  input  wire [7:0]  DEFAULT_VECTOR, // vector of default level 7
  input  wire        INTA1,          // high during first ack cycle
  input  wire        INTA2,          // high during second ack cycle
  output reg         INT_REQ,        // interrupt to host
  output reg  [7:0]  DATA_OUT,       // data bus value
  output reg         DATA_OE_N,      // low while driving the bus
  output reg  [2:0]  ACK_LEVEL,      // level taken at first ack
  output reg         ACK_DEFAULT,    // first ack found no allowed request
  output reg  [7:0]  PENDING,        // request latch state
  output reg  [7:0]  IN_SERVICE,     // in-service bits
  output reg  [7:0]  MASK_STATE,     // mask bits
  output reg  [2:0]  LOWEST_LEVEL,   // level ranked lowest
  output reg         SMM_ON,         // special mask mode active
  output reg         RAEOI_ON,       // rotate auto end mode active
  output reg         AUTO_END_OF_SERVICE_ON         // plain auto end mode active
);

  // pin synchroniser and edge history
  reg  [7:0] irq_s1;     // first stage, read only by irq_s2
  reg  [7:0] irq_s2;     // synchronised pins
  reg  [7:0] irq_prev;   // previous synchronised value

  // bank state
  reg  [7:0] pending_request_latch; // latched requests
  reg  [7:0] level_mask_bits;       // set bit disables a level
  reg  [7:0] in_service_bits;       // routines in service
  reg  [2:0] lowest;                // level with lowest rank
  reg        smm;                   // special mask mode
  reg        raeoi;                 // rotate on auto end mode
  reg        auto_end_of_service;   // plain auto end mode

  // acknowledge tracking
  reg        inta1_d;    // INTA1 one cycle late
  reg        inta2_d;    // INTA2 one cycle late
  reg  [2:0] ack_lvl;    // acknowledged level
  reg        ack_dflt;   // acknowledge returned default
  reg        ack_casc;   // acknowledged level has a slave

  // combinational helpers
  wire [7:0] req_low;    // pins currently low
  wire [7:0] fall;       // high-to-low transitions
  wire [2:0] base;       // level ranked highest
  wire [7:0] live;       // latched and still low
  wire [7:0] eligible;   // requests that may compete
  wire       w_found;    // a request competes
  wire [2:0] w_lvl;      // best competing request
  wire       h_found;    // a level is in service
  wire [2:0] h_lvl;      // highest level in service
  wire [2:0] w_rank;     // rank of best request
  wire [2:0] h_rank;     // rank of highest in service
  wire       allowed;    // best request may interrupt
  wire       inta1_start;
  wire       inta1_end;
  wire       inta2_start;
  wire       inta2_end;
  wire [7:0] w_vec;      // vector of best request
  wire [7:0] a_vec;      // vector of acknowledged level
  wire [7:0] h_hot;      // one-hot of highest service bit
  wire [7:0] c_hot;      // one-hot of command level
  wire       auto_end;   // auto end happens this cycle

  reg  [7:0] next_latch;   // next request latch
  reg  [7:0] latch_clr;    // latch bits cleared by ack
  reg  [7:0] isr_set;      // service bits set by ack
  reg  [7:0] isr_clr;      // service bits cleared
  reg  [2:0] next_lowest;  // next lowest-rank level
  reg        next_smm;     // next special mask mode
  reg        next_raeoi;   // next rotate auto end mode
  reg        next_auto_end_of_service;    // next plain auto end mode

  assign req_low     = ~irq_s2;
  assign fall        = irq_prev & ~irq_s2;
  assign base        = lowest + `LEVEL_STEP;
  assign live        = pending_request_latch & req_low;
  // mask gates only the latch output; special mask drops busy levels
  assign eligible    = live & ~level_mask_bits & (smm ? ~in_service_bits : `BITS_ALL);
  assign w_rank      = w_lvl - base;
  assign h_rank      = h_lvl - base;
  // nested mode: only a strictly better rank than the busy one wins
  assign allowed     = w_found & (smm | ~h_found | (w_rank < h_rank));
  assign inta1_start = INTA1 & ~inta1_d;
  assign inta1_end   = ~INTA1 & inta1_d;
  assign inta2_start = INTA2 & ~inta2_d;
  assign inta2_end   = ~INTA2 & inta2_d;
  assign w_vec       = VECTOR_TABLE[{w_lvl, `VEC_LSB_PAD} +: 8];
  assign a_vec       = VECTOR_TABLE[{ack_lvl, `VEC_LSB_PAD} +: 8];
  assign h_hot       = `ONE_HOT_BASE << h_lvl;
  assign c_hot       = `ONE_HOT_BASE << CMD_LEVEL;
  assign auto_end    = inta2_end & ~ack_dflt & (auto_end_of_service | raeoi);

  // best pending request by current rank
  prio_pick u_req_pick (
    .bits  (eligible),
    .base  (base),
    .found (w_found),
    .level (w_lvl)
  );

  // highest level in service by current rank
  prio_pick u_isr_pick (
    .bits  (in_service_bits),
    .base  (base),
    .found (h_found),
    .level (h_lvl)
  );

  // request latch update, sensing chosen per bank
  always @* begin
    latch_clr = `BITS_CLEAR;
    if (inta1_start && allowed) begin
      latch_clr = `ONE_HOT_BASE << w_lvl;
    end
    if (LEVEL_MODE) begin
      // level sensing follows the pin, no edge needed
      next_latch = req_low;
    end else begin
      // new edge wins over the ack clear
      next_latch = (pending_request_latch & ~latch_clr) | fall;
    end
  end

  // service bits, priority and mode updates
  always @* begin
    isr_set     = `BITS_CLEAR;
    isr_clr     = `BITS_CLEAR;
    next_lowest = lowest;
    next_smm    = smm;
    next_raeoi  = raeoi;
    next_auto_end_of_service   = auto_end_of_service;
    // acknowledge records the winning level
    if (inta1_start && allowed) begin
      isr_set = `ONE_HOT_BASE << w_lvl;
    end
    // automatic end after the second acknowledge
    if (auto_end && h_found) begin
      isr_clr = h_hot;
      if (raeoi) begin
        next_lowest = h_lvl;
      end
    end
    if (CMD_VALID) begin
      case (CMD_CODE)
        `CMD_EOI_NONSPEC: begin
          // clear highest, order unchanged
          if (h_found) begin
            isr_clr = isr_clr | h_hot;
          end
        end
        `CMD_EOI_SPEC: begin
          isr_clr = isr_clr | c_hot;
        end
        `CMD_ROT_NONSPEC: begin
          if (h_found) begin
            isr_clr     = isr_clr | h_hot;
            next_lowest = h_lvl;
          end
        end
        `CMD_ROT_SPEC: begin
          isr_clr     = isr_clr | c_hot;
          next_lowest = CMD_LEVEL;
        end
        `CMD_SET_PRIO: begin
          // rank change only, service bits kept
          next_lowest = CMD_LEVEL;
        end
        `CMD_RAEOI_SET: begin
          next_raeoi = 1'b1;
        end
        `CMD_RAEOI_CLR: begin
          next_raeoi = 1'b0;
        end
        `CMD_SMM_SET: begin
          next_smm = 1'b1;
        end
        `CMD_SMM_CLR: begin
          next_smm = 1'b0;
        end
        `CMD_AUTO_END_OF_SERVICE_SET: begin
          next_auto_end_of_service = 1'b1;
        end
        `CMD_AUTO_END_OF_SERVICE_CLR: begin
          next_auto_end_of_service = 1'b0;
        end
        default: begin
          // unknown code: no effect
          next_smm = smm;
        end
      endcase
    end
  end

  // pin synchroniser and edge history
  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      irq_s1   <= `BITS_ALL;
      irq_s2   <= `BITS_ALL;
      irq_prev <= `BITS_ALL;
    end else begin
      irq_s1   <= IRQ_N;
      irq_s2   <= irq_s1;
      irq_prev <= irq_s2;
    end
  end

  // bank state registers
  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      pending_request_latch <= `BITS_CLEAR;
      level_mask_bits       <= `BITS_CLEAR;
      in_service_bits       <= `BITS_CLEAR;
      lowest                <= `LOWEST_RESET;
      smm                   <= 1'b0;
      raeoi                 <= 1'b0;
      auto_end_of_service   <= 1'b0;
    end else begin
      pending_request_latch <= next_latch;
      if (MASK_WR) begin
        level_mask_bits <= MASK_DATA;
      end
      // a set in the same cycle as a clear wins
      in_service_bits       <= (in_service_bits & ~isr_clr) | isr_set;
      lowest                <= next_lowest;
      smm                   <= next_smm;
      raeoi                 <= next_raeoi;
      auto_end_of_service   <= next_auto_end_of_service;
    end
  end

  // acknowledge sequencing and data bus
  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      inta1_d   <= 1'b0;
      inta2_d   <= 1'b0;
      ack_lvl   <= `DEFAULT_LEVEL;
      ack_dflt  <= 1'b0;
      ack_casc  <= 1'b0;
      DATA_OUT  <= `DATA_IDLE;
      DATA_OE_N <= 1'b1;
    end else begin
      inta1_d <= INTA1;
      inta2_d <= INTA2;
      if (inta1_start) begin
        DATA_OE_N <= 1'b0;
        if (allowed) begin
          ack_lvl  <= w_lvl;
          ack_dflt <= 1'b0;
          ack_casc <= CASCADE_EN[w_lvl];
          // cascade address or zero for a local level
          DATA_OUT <= CASCADE_EN[w_lvl] ? w_vec : `DATA_IDLE;
        end else begin
          // no allowed request (vanished, masked away or outranked by service): default level
          ack_lvl  <= `DEFAULT_LEVEL;
          ack_dflt <= 1'b1;
          ack_casc <= 1'b0;
          DATA_OUT <= `DATA_IDLE;
        end
      end else if (inta1_end) begin
        DATA_OE_N <= 1'b1;
        DATA_OUT  <= `DATA_IDLE;
      end else if (inta2_start) begin
        if (ack_dflt) begin
          DATA_OE_N <= 1'b0;
          DATA_OUT  <= DEFAULT_VECTOR;
        end else if (ack_casc) begin
          // slave drives its own vector
          DATA_OE_N <= 1'b1;
          DATA_OUT  <= `DATA_IDLE;
        end else begin
          DATA_OE_N <= 1'b0;
          DATA_OUT  <= a_vec;
        end
      end else if (inta2_end) begin
        DATA_OE_N <= 1'b1;
        DATA_OUT  <= `DATA_IDLE;
      end
    end
  end

  // registered status and request outputs
  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      INT_REQ      <= 1'b0;
      ACK_LEVEL    <= `DEFAULT_LEVEL;
      ACK_DEFAULT  <= 1'b0;
      PENDING      <= `BITS_CLEAR;
      IN_SERVICE   <= `BITS_CLEAR;
      MASK_STATE   <= `BITS_CLEAR;
      LOWEST_LEVEL <= `LOWEST_RESET;
      SMM_ON       <= 1'b0;
      RAEOI_ON     <= 1'b0;
      AUTO_END_OF_SERVICE_ON      <= 1'b0;
    end else begin
      INT_REQ      <= allowed;
      ACK_LEVEL    <= ack_lvl;
      ACK_DEFAULT  <= ack_dflt;
      PENDING      <= pending_request_latch;
      IN_SERVICE   <= in_service_bits;
      MASK_STATE   <= level_mask_bits;
      LOWEST_LEVEL <= lowest;
      SMM_ON       <= smm;
      RAEOI_ON     <= raeoi;
      AUTO_END_OF_SERVICE_ON      <= auto_end_of_service;
    end
  end

endmodule // irq_bank

`default_nettype wire

// file: irq_bank_defines.vh
// Purpose: constants for the eight-level interrupt bank
// Assumes: included by bare name by the bank design files
// Notes:   command codes arrive on CMD_CODE with a CMD_VALID pulse
`ifndef IRQ_BANK_DEFINES_VH
`define IRQ_BANK_DEFINES_VH

// command codes
`define CMD_EOI_NONSPEC   4'h0
`define CMD_EOI_SPEC      4'h1
`define CMD_ROT_NONSPEC   4'h2
`define CMD_ROT_SPEC      4'h3
`define CMD_SET_PRIO      4'h4
`define CMD_RAEOI_SET     4'h5
`define CMD_RAEOI_CLR     4'h6
`define CMD_SMM_SET       4'h7
`define CMD_SMM_CLR       4'h8
`define CMD_AUTO_END_OF_SERVICE_SET      4'h9
`define CMD_AUTO_END_OF_SERVICE_CLR      4'ha

// reset values and fixed codes
`define LOWEST_RESET      3'h7
`define DEFAULT_LEVEL     3'h7
`define BITS_CLEAR        8'h00
`define BITS_ALL          8'hff
`define ONE_HOT_BASE      8'h01
`define DATA_IDLE         8'h00
`define LEVEL_STEP        3'h1
`define VEC_LSB_PAD       3'h0

`endif

// file: irq_bank_sva.sv
// Purpose: port checker for one interrupt bank
// Assumes: bound to irq_bank, one clock domain
// Notes:   watches design outputs against their causes
`timescale 1ns/100ps
`default_nettype none
module irq_bank_sva (
  input wire logic        CLK,
  input wire logic        RESET_N,
  input wire logic        INTA1,
  input wire logic        INTA2,
  input wire logic [7:0]  CASCADE_EN,
  input wire logic        CMD_VALID,
  input wire logic [3:0]  CMD_CODE,
  input wire logic [2:0]  CMD_LEVEL,
  input wire logic        INT_REQ,
  input wire logic        DATA_OE_N,
  input wire logic [2:0]  ACK_LEVEL,
  input wire logic        ACK_DEFAULT,
  input wire logic [7:0]  PENDING,
  input wire logic [7:0]  IN_SERVICE,
  input wire logic [7:0]  MASK_STATE,
  input wire logic [2:0]  LOWEST_LEVEL,
  input wire logic        SMM_ON,
  input wire logic        RAEOI_ON
);
  logic smm_clr;  // special mask clear command taken
  logic rot_clr;  // rotate auto mode clear command taken
  assign smm_clr = CMD_VALID && CMD_CODE == 4'h8;
  assign rot_clr = CMD_VALID && CMD_CODE == 4'h6;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  chk_ack_drive: assert property ($rose(INTA1) |-> ##[1:2] !DATA_OE_N)
    else $error("bus not driven after first ack");
  chk_slave_float: assert property ($rose(INTA2) && CASCADE_EN[ACK_LEVEL] && !ACK_DEFAULT |-> DATA_OE_N [*3])
    else $error("bus driven in second ack of slave level");
  chk_bus_release: assert property ((!INTA1 && !INTA2) [*3] |-> DATA_OE_N)
    else $error("bus driven outside ack");
  chk_mask_gate: assert property (((PENDING & ~MASK_STATE) == 8'h00) [*3] |-> !INT_REQ)
    else $error("interrupt with no unmasked request");
  chk_isr_set: assert property ($rose(INTA1) |-> ##3 (ACK_DEFAULT || IN_SERVICE[ACK_LEVEL]))
    else $error("acked level not in service");
  chk_default_lvl: assert property ($rose(INTA1) |-> ##3 (!ACK_DEFAULT || ACK_LEVEL == 3'h7))
    else $error("default ack not at level 7");
  chk_reset_state: assert property ($rose(RESET_N) |-> LOWEST_LEVEL == 3'h7 && !SMM_ON && !RAEOI_ON)
    else $error("bad state after reset");
  // state outputs show a command two edges later; a later command may follow at once
  chk_set_prio: assert property (CMD_VALID && CMD_CODE == 4'h4 |-> ##2 LOWEST_LEVEL == $past(CMD_LEVEL, 2))
    else $error("set priority missed");
  chk_rot_spec: assert property (CMD_VALID && CMD_CODE == 4'h3 |-> ##2
    LOWEST_LEVEL == $past(CMD_LEVEL, 2) && !IN_SERVICE[$past(CMD_LEVEL, 2)])
    else $error("rotate specific missed");
  chk_smm_hold: assert property ($fell(SMM_ON) |-> $past(smm_clr, 2) || $past(smm_clr, 3))
    else $error("special mask left without command");
  chk_raeoi_hold: assert property ($fell(RAEOI_ON) |-> $past(rot_clr, 2) || $past(rot_clr, 3))
    else $error("rotate auto mode left without command");
  // main scenarios
  cov_slave: cover property ($rose(INTA2) && CASCADE_EN[ACK_LEVEL]);
  cov_default: cover property (ACK_DEFAULT);
  cov_smm_req: cover property (SMM_ON && INT_REQ);
endmodule // irq_bank_sva
bind irq_bank irq_bank_sva u_sva (.*);
`default_nettype wire

// file: irq_slave_model.sv
// Purpose: external slave controller behind a cascaded level
// Assumes: cascade address shows on the bus in the first ack
// Notes:   off the bus it shows a toggling pattern
`timescale 1ns/100ps
`default_nettype none
module irq_slave_model #(
  parameter [7:0] SEL_ADDR = 8'h41, // nonzero address
  parameter [7:0] OWN_VEC  = 8'h9c  // vector this slave returns
) (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic [7:0] data_in,
  input  wire logic       data_oe_n,
  input  wire logic       inta1,
  input  wire logic       inta2,
  output var  logic [7:0] slave_bus
);
  logic [7:0] addr;  // latched cascade address
  // latch address in first ack, answer in second
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      addr      <= 8'h00;
      slave_bus <= 8'h00;
    end else begin
      if (inta1 && !data_oe_n) addr <= data_in;
      slave_bus <= (inta2 && addr == SEL_ADDR) ? OWN_VEC : ~slave_bus;
    end
  end
endmodule // irq_slave_model
`default_nettype wire

// file: prio_pick.v
// Purpose: finds the first set bit of a byte in circular order
// Assumes: base is the level currently ranked highest
// Notes:   purely combinational; used for requests and service bits
`timescale 1ns/100ps
`default_nettype none

module prio_pick (
  input  wire [7:0] bits,   // candidate bits, one per level
  input  wire [2:0] base,   // level holding top rank
  output reg        found,  // some bit is set
  output reg  [2:0] level   // best-ranked set level
);

  reg [2:0] idx;  // level under test
  integer   i;    // rank offset

  // walk from lowest rank up so the best rank is written last
  always @* begin
    found = 1'b0;
    level = base;
    idx   = base;
    for (i = 7; i >= 0; i = i - 1) begin
      idx = base + i[2:0];
      if (bits[idx]) begin
        found = 1'b1;
        level = idx;
      end
    end
  end

endmodule // prio_pick

`default_nettype wire

// file: tb_top.sv
// Purpose: directed test of the interrupt bank
// Assumes: inputs driven on the falling clock edge
// Notes: host never nests under auto end modes
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic        CLK = 0, RESET_N = 0, LEVEL_MODE = 0, MASK_WR = 0, CMD_VALID = 0, INTA1 = 0, INTA2 = 0;
  logic [7:0]  IRQ_N = 8'hff, MASK_DATA = 8'h00, CASCADE_EN = 8'h02, DEFAULT_VECTOR = 8'h5a;
  logic [63:0] VECTOR_TABLE = 64'h4746_4544_4342_4140;
  logic [3:0]  CMD_CODE = 4'h0;
  logic [2:0]  CMD_LEVEL = 3'h0, ACK_LEVEL, LOWEST_LEVEL;
  logic        INT_REQ, DATA_OE_N, ACK_DEFAULT, SMM_ON, RAEOI_ON, AUTO_END_OF_SERVICE_ON;
  logic [7:0]  DATA_OUT, PENDING, IN_SERVICE, MASK_STATE, slave_bus, bus;
  int          failures = 0, n_compared = 0;
  irq_bank u_dut (.*);
  irq_slave_model u_slave (.clk(CLK), .reset_n(RESET_N), .data_in(DATA_OUT), .data_oe_n(DATA_OE_N),
    .inta1(INTA1), .inta2(INTA2), .slave_bus(slave_bus));
  // bus as the host sees it
  assign bus = DATA_OE_N ? slave_bus : DATA_OUT;
  always #20 CLK = ~CLK;
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task results;
    if (failures == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task tick(input int n);
    repeat (n) @(negedge CLK);
  endtask
  // one command pulse, then room for the state outputs to follow
  task cmd(input logic [3:0] c, input logic [2:0] l);
    CMD_CODE  = c;
    CMD_LEVEL = l;
    CMD_VALID = 1'b1;
    tick(1);
    CMD_VALID = 1'b0;
    tick(3);
  endtask
  // move one pin, long enough to pass the synchroniser
  task pin(input int n, input logic v);
    IRQ_N[n] = v;
    tick(6);
  endtask
  task mask(input logic [7:0] m);
    MASK_DATA = m;
    MASK_WR   = 1'b1;
    tick(1);
    MASK_WR   = 1'b0;
    tick(3);
  endtask
  // full two-cycle acknowledge, bus checked in each
  task ack(input logic [7:0] d1, input logic [7:0] d2);
    INTA1 = 1'b1;
    tick(3);
    chk(DATA_OE_N, 8'h00);
    chk(DATA_OUT, d1);
    INTA1 = 1'b0;
    tick(3);
    chk(DATA_OE_N, 8'h01);
    INTA2 = 1'b1;
    tick(3);
    chk(bus, d2);
    INTA2 = 1'b0;
    tick(4);
  endtask
  initial begin
    tick(4);
    RESET_N = 1;
    tick(2);
    chk(LOWEST_LEVEL, 8'h07);
    chk({SMM_ON, RAEOI_ON, AUTO_END_OF_SERVICE_ON, DATA_OE_N}, 8'h01);
    // nested order, then rotation
    IRQ_N[6] = 0;
    pin(4, 0);
    ack(8'h00, 8'h44);
    chk(ACK_LEVEL, 8'h04);
    chk(IN_SERVICE, 8'h10);
    chk(INT_REQ, 8'h00);
    cmd(4'h2, 3'h0);
    chk(LOWEST_LEVEL, 8'h04);
    chk(IN_SERVICE, 8'h00);
    pin(3, 0);
    ack(8'h00, 8'h46);
    cmd(4'h0, 3'h0);
    chk(IN_SERVICE, 8'h00);
    chk(LOWEST_LEVEL, 8'h04);
    ack(8'h00, 8'h43);
    cmd(4'h4, 3'h2);
    chk(IN_SERVICE, 8'h08);
    chk(LOWEST_LEVEL, 8'h02);
    cmd(4'h3, 3'h3);
    chk({IN_SERVICE[3], LOWEST_LEVEL}, 8'h03);
    chk(INT_REQ, 8'h00);
    // masking
    mask(8'h20);
    chk(MASK_STATE, 8'h20);
    pin(5, 0);
    chk(PENDING, 8'h20);
    chk(INT_REQ, 8'h00);
    pin(0, 0);
    ack(8'h00, 8'h40);
    cmd(4'h1, 3'h0);
    mask(8'h00);
    chk(INT_REQ, 8'h01);
    ack(8'h00, 8'h45);
    cmd(4'h0, 3'h0);
    IRQ_N = 8'hff;
    tick(6);
    // cascaded slave, then special mask
    pin(1, 0);
    ack(8'h41, 8'h9c);
    cmd(4'h7, 3'h0);
    pin(2, 0);
    chk(INT_REQ, 8'h01);
    cmd(4'h9, 3'h0);
    chk({SMM_ON, AUTO_END_OF_SERVICE_ON}, 8'h03);
    cmd(4'ha, 3'h0);
    cmd(4'h8, 3'h0);
    chk({SMM_ON, AUTO_END_OF_SERVICE_ON, INT_REQ}, 8'h00);
    cmd(4'h1, 3'h1);
    cmd(4'h5, 3'h0);
    chk(RAEOI_ON, 8'h01);
    ack(8'h00, 8'h42);
    chk(IN_SERVICE, 8'h00);
    chk(LOWEST_LEVEL, 8'h02);
    cmd(4'h6, 3'h0);
    chk(RAEOI_ON, 8'h00);
    IRQ_N = 8'hff;
    tick(6);
    // level sensing, vanished masked request
    LEVEL_MODE = 1;
    mask(8'h40);
    pin(6, 0);
    chk(PENDING, 8'h40);
    pin(6, 1);
    mask(8'h00);
    ack(8'h00, 8'h5a);
    chk({ACK_DEFAULT, ACK_LEVEL}, 8'h0f);
    pin(0, 0);
    ack(8'h00, 8'h40);
    cmd(4'h0, 3'h0);
    chk(INT_REQ, 8'h01);
    pin(0, 1);
    chk(INT_REQ, 8'h00);
    // plain auto end clears service but keeps the order
    cmd(4'h9, 3'h0);
    pin(7, 0);
    ack(8'h00, 8'h47);
    chk(IN_SERVICE, 8'h00);
    chk(LOWEST_LEVEL, 8'h02);
    pin(7, 1);
    // second reset in mid-run, auto end still on
    RESET_N = 0;
    tick(2);
    RESET_N = 1;
    tick(2);
    chk(LOWEST_LEVEL, 8'h07);
    chk({SMM_ON, RAEOI_ON, AUTO_END_OF_SERVICE_ON, DATA_OE_N}, 8'h01);
    results;
  end
  // cut a hang short
  initial begin
    #100000;
    failures++;
    results;
  end
endmodule // tb_top
`default_nettype wire
